// File: hdl/dlps_pkg.sv
// constants for the drive link port sequencer
package dlps_pkg;
    localparam int NUM_REQ = 4;
    localparam int CLK_HZ = 25_000_000;
    localparam int START_WAIT_MS = 15;
    localparam int START_WAIT_CYCLES = (CLK_HZ / 1000) * START_WAIT_MS;
    localparam logic [3:0] monitor_function_code = 4'hA;
    localparam logic [3:0] control_function_code = 4'hB;
    localparam logic [3:0] param_read_function_code = 4'hC;
    localparam logic [3:0] param_write_function_code = 4'hD;
    // register byte addresses (word aligned)
    localparam logic [7:0] ADDR_REPLY_WAIT = 8'h00;
    localparam logic [7:0] ADDR_OWNER_STEP = 8'h04;
    localparam logic [7:0] ADDR_ERR_CODE = 8'h08;
    localparam logic [7:0] ADDR_ERR_STEP = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_REQ_CFG0 = 8'h20;
    localparam logic [15:0] REPLY_WAIT_RESET = 16'h0000;
    localparam logic [15:0] NO_ERROR_STEP = 16'hFFFF;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] ERR_CODE_TIMEOUT = 16'h0001;
    localparam int FLAG_DONE_BIT = 0;
    localparam int FLAG_BUSY_BIT = 1;
    localparam int FLAG_REQ_ERR_BIT = 2;
    localparam int FLAG_LATCH_BIT = 3;
    typedef enum logic [1:0] {DLPS_IDLE, DLPS_WAIT, DLPS_XFER} dlps_state_t;
endpackage : dlps_pkg

// File: hdl/dlps_edge.sv
// per-request drive condition sampler and rising-edge arm at scan boundaries
`timescale 1ns/1ps
`default_nettype none
module dlps_edge
    import dlps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // scan strobe and condition
    input wire logic scan_strobe,
    input wire logic drive_cond,
    input wire logic served,
    // result
    output logic armed
);
    logic prev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else if (scan_strobe) begin
            prev_reg <= drive_cond;
        end
    end

    // an edge arms; a level that stays high re-arms after serving
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (scan_strobe && drive_cond && (!prev_reg || !armed)) begin
            armed <= 1'b1;
        end else if (served) begin
            armed <= 1'b0;
        end else if (!drive_cond) begin
            armed <= 1'b0;
        end
    end
endmodule : dlps_edge
`default_nettype wire

// File: hdl/dlps_top.sv
// drive link port sequencer: arbitration, timing, flags and wishbone registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - completion flag is high for exactly one scan after each request ends.
// - completion flag pulses too when the request ended in error.
// - port busy flag stays high while a request owns the port.
// - per-request error flag set when the request has a communication error.
// - sticky error latch set on any error, held until cleared.
// - run-mode start clears latch, error code and error step.
// - reply wait time register is read/write and bounds the reply wait.
// - step number of the port owner readable in a read-only register.
// - on an error the matching code is written to the error code register.
// - error step holds failing step, reads all ones (-1) with no error.
// - function codes: monitor, control, parameter read, parameter write.
// - transfer starts on rising edge of the request drive condition.
// - a begun transfer completes even if its condition drops.
// - a condition held high repeats the communication.
// - concurrent requests served one at a time in program order.
// - wait 15 ms after acquiring the port before the transfer.
// - a request does not start while another holds the busy flag.
// - busy flag stays low after completion until next request drives.
// - a pending request whose condition is low when port frees is skipped.
// - request error flag reflects each individual request result; error code keeps the last failing code.
module dlps_top
    import dlps_pkg::*;
#(
    // start delay in clock cycles; a bench may shorten it to keep runs brief
    parameter int WAIT_CYCLES = START_WAIT_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // controller run-mode entry and scan boundary
    input wire logic run_start,
    input wire logic scan_strobe,
    // drive conditions of the requests, index = program order
    input wire logic [NUM_REQ-1:0] drive_comm_request,
    // link transfer engine handshake
    output logic xfer_start,
    output logic [3:0] xfer_function,
    output logic [15:0] xfer_timeout,
    input wire logic xfer_done,
    input wire logic xfer_error,
    input wire logic [15:0] xfer_error_code,
    // status flags
    output logic completion_pulse_flag,
    output logic port_busy_flag,
    output logic request_error_flag,
    output logic error_latch_flag,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    dlps_state_t state_reg;
    logic [NUM_REQ-1:0] armed;
    logic [NUM_REQ-1:0] served_reg;
    logic [1:0] owner_reg;
    logic [24:0] wait_cnt_reg;
    logic [15:0] reply_wait_time_reg;
    logic [15:0] port_owner_step_reg;
    logic [15:0] comm_error_code_reg;
    logic [15:0] error_step_latch_reg;
    logic [3:0] req_func_reg [NUM_REQ];
    logic [15:0] req_step_reg [NUM_REQ];
    logic done_pend_reg;
    logic wb_req;
    logic pick_valid;
    logic [1:0] pick_idx;
    logic [1:0] cand_idx;
    logic [2:0] cfg_idx;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
            dlps_edge u_edge (
                .clk(clk),
                .rst(rst || run_start),
                .scan_strobe(scan_strobe),
                .drive_cond(drive_comm_request[gi]),
                .served(served_reg[gi]),
                .armed(armed[gi])
            );
        end
    endgenerate

    // program order resumes after the last owner, so a held request cannot starve the rest
    always_comb begin
        pick_valid = 1'b0;
        pick_idx = 2'd0;
        cand_idx = 2'd0;
        for (int k = NUM_REQ; k >= 1; k--) begin
            cand_idx = owner_reg + k[1:0];
            if (armed[cand_idx]) begin
                pick_valid = 1'b1;
                pick_idx = cand_idx;
            end
        end
    end

    // port ownership sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= DLPS_IDLE;
            owner_reg <= 2'(NUM_REQ - 1);
            wait_cnt_reg <= '0;
            xfer_start <= 1'b0;
            served_reg <= '0;
            port_busy_flag <= 1'b0;
        end else if (run_start) begin
            state_reg <= DLPS_IDLE;
            owner_reg <= 2'(NUM_REQ - 1);
            xfer_start <= 1'b0;
            served_reg <= '0;
            port_busy_flag <= 1'b0;
        end else begin
            xfer_start <= 1'b0;
            served_reg <= '0;
            case (state_reg)
                DLPS_IDLE: begin
                    if (pick_valid) begin
                        owner_reg <= pick_idx;
                        wait_cnt_reg <= '0;
                        port_busy_flag <= 1'b1;
                        served_reg[pick_idx] <= 1'b1;
                        state_reg <= DLPS_WAIT;
                    end else begin
                        port_busy_flag <= 1'b0;
                    end
                end
                DLPS_WAIT: begin
                    if (wait_cnt_reg == 25'(WAIT_CYCLES - 1)) begin
                        xfer_start <= 1'b1;
                        state_reg <= DLPS_XFER;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg + 25'd1;
                    end
                end
                DLPS_XFER: begin
                    if (xfer_done) begin
                        port_busy_flag <= 1'b0;
                        state_reg <= DLPS_IDLE;
                    end
                end
                default: state_reg <= DLPS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_function <= 4'h0;
            xfer_timeout <= REPLY_WAIT_RESET;
            port_owner_step_reg <= ZERO_WORD;
        end else if (state_reg == DLPS_IDLE && pick_valid) begin
            xfer_function <= req_func_reg[pick_idx];
            xfer_timeout <= reply_wait_time_reg;
            port_owner_step_reg <= req_step_reg[pick_idx];
        end
    end

    // one-scan completion pulse, raised at the first scan boundary after end of transfer and dropped at the next
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_pend_reg <= 1'b0;
            completion_pulse_flag <= 1'b0;
        end else if (run_start) begin
            done_pend_reg <= 1'b0;
            completion_pulse_flag <= 1'b0;
        end else begin
            if (state_reg == DLPS_XFER && xfer_done) begin
                done_pend_reg <= 1'b1;
            end else if (scan_strobe) begin
                done_pend_reg <= 1'b0;
            end
            if (scan_strobe) begin
                completion_pulse_flag <= done_pend_reg;
            end
        end
    end

    // per-request result and sticky error history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            request_error_flag <= 1'b0;
            error_latch_flag <= 1'b0;
            comm_error_code_reg <= ZERO_WORD;
            error_step_latch_reg <= NO_ERROR_STEP;
        end else if (run_start) begin
            request_error_flag <= 1'b0;
            error_latch_flag <= 1'b0;
            comm_error_code_reg <= ZERO_WORD;
            error_step_latch_reg <= NO_ERROR_STEP;
        end else if (state_reg == DLPS_XFER && xfer_done) begin
            request_error_flag <= xfer_error;
            if (xfer_error) begin
                error_latch_flag <= 1'b1;
                comm_error_code_reg <= xfer_error_code;
                error_step_latch_reg <= port_owner_step_reg;
            end
        end
    end

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cfg_idx = wb_adr_i[4:2];

    // software writes; reply wait time and per-request configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reply_wait_time_reg <= REPLY_WAIT_RESET;
            for (int i = 0; i < NUM_REQ; i++) begin
                req_func_reg[i] <= monitor_function_code;
                req_step_reg[i] <= ZERO_WORD;
            end
        // writes land at the ack edge, while the master still holds the request
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            if (wb_adr_i == ADDR_REPLY_WAIT) begin
                if (wb_sel_i[0]) reply_wait_time_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) reply_wait_time_reg[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i[7:5] == ADDR_REQ_CFG0[7:5] && cfg_idx < 3'd4) begin
                if (wb_sel_i[0]) req_func_reg[cfg_idx[1:0]] <= wb_dat_i[3:0];
                if (wb_sel_i[2]) req_step_reg[cfg_idx[1:0]][7:0] <= wb_dat_i[23:16];
                if (wb_sel_i[3]) req_step_reg[cfg_idx[1:0]][15:8] <= wb_dat_i[31:24];
            end
        end
    end

    // reads; unmapped addresses return zero and still acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    ADDR_REPLY_WAIT: wb_dat_o <= {16'h0000, reply_wait_time_reg};
                    ADDR_OWNER_STEP: wb_dat_o <= {16'h0000, port_owner_step_reg};
                    ADDR_ERR_CODE: wb_dat_o <= {16'h0000, comm_error_code_reg};
                    ADDR_ERR_STEP: wb_dat_o <= {16'h0000, error_step_latch_reg};
                    ADDR_FLAGS: begin
                        wb_dat_o[FLAG_DONE_BIT] <= completion_pulse_flag;
                        wb_dat_o[FLAG_BUSY_BIT] <= port_busy_flag;
                        wb_dat_o[FLAG_REQ_ERR_BIT] <= request_error_flag;
                        wb_dat_o[FLAG_LATCH_BIT] <= error_latch_flag;
                    end
                    default: begin
                        if (wb_adr_i[7:5] == ADDR_REQ_CFG0[7:5] && cfg_idx < 3'd4) begin
                            wb_dat_o <= {req_step_reg[cfg_idx[1:0]], 12'h000,
                                         req_func_reg[cfg_idx[1:0]]};
                        end
                    end
                endcase
            end
        end
    end
endmodule : dlps_top
`default_nettype wire

// File: dv/dlps_top_properties.sv
// port assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module dlps_top_properties
    import dlps_pkg::*;
#(
    parameter int WAIT_CYCLES = START_WAIT_CYCLES
)
(
    // clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic run_start,
    input wire logic scan_strobe,
    // link and flags
    input wire logic xfer_start,
    input wire logic xfer_done,
    input wire logic xfer_error,
    input wire logic completion_pulse_flag,
    input wire logic port_busy_flag,
    input wire logic request_error_flag,
    input wire logic error_latch_flag,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [19:0] wait_cnt;
    // cycles since the port was taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) wait_cnt <= 20'h0;
        else wait_cnt <= port_busy_flag ? wait_cnt + 20'h1 : 20'h0;
    end
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_ack_once: assert property (s_take |=> s_ack)
        else $error("bus ack not one cycle");
    a_start_after_wait: assert property (
        xfer_start |-> wait_cnt == 20'(WAIT_CYCLES))
        else $error("start delay after port taken is wrong");
    a_busy_drop: assert property (xfer_done && port_busy_flag |=> !port_busy_flag)
        else $error("busy held after done");
    a_scan_aligned: assert property (
        $changed(completion_pulse_flag) && !$past(run_start) |-> $past(scan_strobe))
        else $error("completion moved off a scan boundary");
    a_done_one_scan: assert property (
        completion_pulse_flag && scan_strobe && !run_start |=> !completion_pulse_flag)
        else $error("completion longer than one scan");
    a_err_flags_set: assert property (
        xfer_done && xfer_error && port_busy_flag |=> request_error_flag && error_latch_flag)
        else $error("error flags not set");
    a_latch_sticky: assert property (error_latch_flag && !run_start |=> error_latch_flag)
        else $error("latch lost");
    a_run_clears: assert property (
        run_start |=> !(error_latch_flag || completion_pulse_flag || port_busy_flag))
        else $error("run start did not clear");
endmodule : dlps_top_properties
bind dlps_top dlps_top_properties #(.WAIT_CYCLES(WAIT_CYCLES)) dlps_top_properties_inst (
    .clk(clk), .rst(rst),
    .run_start(run_start), .scan_strobe(scan_strobe), .xfer_start(xfer_start),
    .xfer_done(xfer_done), .xfer_error(xfer_error),
    .completion_pulse_flag(completion_pulse_flag), .port_busy_flag(port_busy_flag),
    .request_error_flag(request_error_flag), .error_latch_flag(error_latch_flag),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// File: dv/dlps_link_model.sv
// link transfer engine model
`timescale 1ns/1ps
`default_nettype none
module dlps_link_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench controls
    input wire logic slow,
    input wire logic fail,
    input wire logic [15:0] code,
    // sequencer side
    input wire logic xfer_start,
    output logic xfer_done,
    output logic xfer_error,
    output logic [15:0] xfer_error_code
);
    logic [7:0] cnt_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h0;
            xfer_done <= 1'b0;
            xfer_error <= 1'b0;
            xfer_error_code <= 16'h0;
        end else begin
            // result lines invert every cycle outside the done cycle so data sampled one cycle late never matches
            xfer_done <= 1'b0;
            xfer_error <= ~xfer_error;
            xfer_error_code <= ~xfer_error_code;
            if (xfer_start) cnt_reg <= slow ? 8'hC8 : 8'h3;
            else if (cnt_reg != 8'h0) cnt_reg <= cnt_reg - 8'h1;
            if (cnt_reg == 8'h1) begin
                xfer_done <= 1'b1;
                xfer_error <= fail;
                xfer_error_code <= code;
            end
        end
    end
endmodule : dlps_link_model
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dlps_pkg::*;
    logic clk, rst, run_start, scan_strobe, xfer_start, xfer_done, xfer_error, wb_cyc_i;
    logic wb_stb_i, wb_we_i, wb_ack_o, slow, fail, comp_d;
    logic completion_pulse_flag, port_busy_flag, request_error_flag, error_latch_flag;
    logic [3:0] drive_comm_request, xfer_function;
    logic [15:0] xfer_timeout, xfer_error_code, code, tmo;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [2:0] scnt;
    int miscompares, n_compared, n_comp, seed;
    logic [3:0] fn [4];
    logic [15:0] st [4];
    int exp_q [$];
    // shortened start delay keeps the run brief
    localparam int SIM_WAIT = 200;
    dlps_top #(.WAIT_CYCLES(SIM_WAIT)) dlps_top_inst (.clk, .rst, .run_start, .scan_strobe,
        .drive_comm_request,
        .xfer_start, .xfer_function, .xfer_timeout, .xfer_done, .xfer_error,
        .xfer_error_code, .completion_pulse_flag, .port_busy_flag, .request_error_flag,
        .error_latch_flag, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
        .wb_dat_i, .wb_dat_o, .wb_ack_o);
    dlps_link_model dlps_link_model_inst (.clk, .rst, .slow, .fail, .code, .xfer_start,
        .xfer_done, .xfer_error, .xfer_error_code);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        scnt <= rst ? 3'h0 : scnt + 3'h1;
        scan_strobe <= !rst && scnt == 3'h7;
        comp_d <= completion_pulse_flag;
        if (completion_pulse_flag === 1'b1 && comp_d !== 1'b1) n_comp <= n_comp + 1;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // ack and read data are taken at the rising edge that sees ack high
        for (i = 0; i < 9; i++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 9) begin
            miscompares++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            finish_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic wait_ev(input int k);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (k == 0 ? xfer_start === 1'b1 : n_comp >= k) break;
        end
        if (i == 4000) begin
            miscompares++;
            $display("CHECK FAILED at %0t: event timeout", $time);
            finish_test();
        end
        @(posedge clk);
    endtask : wait_ev
    initial begin
        {rst, run_start, wb_cyc_i, wb_stb_i, wb_we_i, slow, fail} = 7'h40;
        {drive_comm_request, wb_adr_i, wb_dat_i, code} = '0;
        seed = 32'hd6199f17;
        fn = '{monitor_function_code, control_function_code, param_read_function_code,
            param_write_function_code};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_REPLY_WAIT, 32'h0);
        rd(ADDR_ERR_STEP, 32'(NO_ERROR_STEP));
        rd(8'h3C, 32'h0);
        tmo = 16'($random(seed));
        wb(ADDR_REPLY_WAIT, 1'b1, 32'(tmo));
        rd(ADDR_REPLY_WAIT, 32'(tmo));
        for (int i = 0; i < 4; i++) begin
            st[i] = 16'($random(seed));
            wb(ADDR_REQ_CFG0 + 8'(4 * i), 1'b1, {st[i], 12'h0, fn[i]});
        end
        fail <= 1'b1;
        slow <= 1'b1;
        code <= 16'($random(seed)) | 16'h1;
        drive_comm_request <= 4'hA;
        exp_q = {1, 3};
        for (int t = 1; t <= 2; t++) begin
            wait_ev(0);
            drive_comm_request[exp_q[0]] <= 1'b0;
            chk(32'(xfer_function), 32'(fn[exp_q[0]]));
            chk(32'(xfer_timeout), 32'(tmo));
            rd(ADDR_OWNER_STEP, 32'(st[exp_q.pop_front()]));
            drive_comm_request[2] <= t == 1;
            repeat (20) @(posedge clk);
            drive_comm_request[2] <= 1'b0;
            wait_ev(t);
            chk(32'({request_error_flag, error_latch_flag}), {30'h0, t == 1, 1'b1});
            rd(ADDR_ERR_STEP, 32'(st[1]));
            rd(ADDR_ERR_CODE, 32'(code));
            fail <= 1'b0;
            slow <= 1'b0;
        end
        repeat (40) @(posedge clk);
        rd(ADDR_FLAGS, 32'h8);
        run_start <= 1'b1;
        @(posedge clk);
        run_start <= 1'b0;
        rd(ADDR_ERR_STEP, 32'(NO_ERROR_STEP));
        rd(ADDR_ERR_CODE, 32'h0);
        chk({error_latch_flag, 31'(n_comp)}, 32'h2);
        // two held requests alternate in program order and request 0 repeats
        drive_comm_request <= 4'h3;
        exp_q = {0, 1, 0};
        while (exp_q.size() > 0) begin
            wait_ev(0);
            chk(32'(port_busy_flag), 32'h1);
            chk(32'(xfer_function), 32'(fn[exp_q.pop_front()]));
        end
        drive_comm_request <= 4'h0;
        finish_test();
    end
endmodule : tb
`default_nettype wire
